//--- rtl/cip_io_ports.sv
// Four 8-bit configurable I/O ports with data-memory mapped registers
`include "cip_defines.svh"

module cip_io_ports (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input cip_pkg::cip_bus_req_type bus_req_in,
  output logic [7:0] rd_data_out,
  input cip_pkg::cip_port_vec_type pin_in,
  output cip_pkg::cip_port_vec_type pin_out_out,
  output cip_pkg::cip_port_vec_type pin_oe_out,
  output cip_pkg::cip_port_vec_type pin_pull_out,
  output logic [7:0] wakeup_level_out,
  output cip_pkg::cip_timer_in_type timer_inputs_out,
  output cip_pkg::cip_serial_in_type serial_inputs_out,
  input wire logic serial_transmit_en_in,
  input wire logic serial_transmit_pin_in
);
  import cip_pkg::*;

  cip_port_vec_type cfg_q, cfg_d;
  cip_port_vec_type data_q, data_d;
  cip_port_vec_type sync1_q, sync1_d;
  cip_port_vec_type sync2_q, sync2_d;
  cip_port_vec_type sync3_q, sync3_d;
  cip_port_vec_type level_q, level_d;
  cip_port_vec_type out_q, out_d;
  cip_port_vec_type oe_q, oe_d;
  cip_port_vec_type pull_q, pull_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] wake_q, wake_d;
  cip_timer_in_type timer_q, timer_d;
  cip_serial_in_type serial_q, serial_d;

  logic sel;
  logic [1:0] port_idx;
  logic [1:0] field;

  assign sel = (bus_req_in.addr[`CIP_BASE_HI_MSB:`CIP_BASE_HI_LSB] == `CIP_BASE_HI);
  assign port_idx = bus_req_in.addr[`CIP_PORT_SEL_MSB:`CIP_PORT_SEL_LSB];
  assign field = bus_req_in.addr[`CIP_FIELD_MSB:`CIP_FIELD_LSB];

  // Per-port register writes; the pin address takes no write
  for (genvar p = 0; p < `CIP_NUM_PORTS; p++)
  begin : g_port
    always_comb
    begin
      cfg_d[p] = cfg_q[p];
      data_d[p] = data_q[p];
      if (bus_req_in.wr && sel && (port_idx == 2'(p)))
      begin
        if (field == `CIP_OFS_CFG)
        begin
          cfg_d[p] = bus_req_in.wdata;
        end
        else if (field == `CIP_OFS_DATA)
        begin
          data_d[p] = bus_req_in.wdata;
        end
      end
    end
  end

  // Read mux: one-cycle latency, unmapped field reads zero
  always_comb
  begin
    rdata_d = `CIP_RDATA_RESET;
    if (bus_req_in.rd && sel)
    begin
      unique case (field)
        `CIP_OFS_DATA: rdata_d = data_q[port_idx];
        `CIP_OFS_CFG: rdata_d = cfg_q[port_idx];
        `CIP_OFS_PIN: rdata_d = level_q[port_idx];
        `CIP_OFS_NONE: rdata_d = `CIP_RDATA_RESET;
      endcase
    end
  end

  // Three-stage synchroniser; level moves only when stages two and three agree
  always_comb
  begin
    sync1_d = pin_in;
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    level_d = (level_q & (sync2_q ^ sync3_q)) | (sync3_q & ~(sync2_q ^ sync3_q));
  end

  // Pad drive follows the next register contents so pads change with the write
  always_comb
  begin
    out_d = data_d;
    oe_d = cfg_d;
    pull_d = ~cfg_d & data_d;
    if (serial_transmit_en_in)
    begin
      out_d[`CIP_IDX_WAKE_PORT][`CIP_BIT_SER_TX] = serial_transmit_pin_in;
      oe_d[`CIP_IDX_WAKE_PORT][`CIP_BIT_SER_TX] = 1'b1;
      pull_d[`CIP_IDX_WAKE_PORT][`CIP_BIT_SER_TX] = 1'b0;
    end
  end

  // Alternate-function inputs taken from the filtered wakeup port levels
  always_comb
  begin
    wake_d = level_d[`CIP_IDX_WAKE_PORT];
    timer_d.timer3_input_b = level_d[`CIP_IDX_WAKE_PORT][`CIP_BIT_TIMER3_B];
    timer_d.timer3_input_a = level_d[`CIP_IDX_WAKE_PORT][`CIP_BIT_TIMER3_A];
    timer_d.timer2_input_b = level_d[`CIP_IDX_WAKE_PORT][`CIP_BIT_TIMER2_B];
    timer_d.timer2_input_a = level_d[`CIP_IDX_WAKE_PORT][`CIP_BIT_TIMER2_A];
    serial_d.serial_receive_pin = level_d[`CIP_IDX_WAKE_PORT][`CIP_BIT_SER_RX];
    serial_d.serial_clock_pin = level_d[`CIP_IDX_WAKE_PORT][`CIP_BIT_SER_CLK];
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cfg_q <= {`CIP_NUM_PORTS{`CIP_CFG_RESET}};
      data_q <= {`CIP_NUM_PORTS{`CIP_DATA_RESET}};
    end
    else
    begin
      cfg_q <= cfg_d;
      data_q <= data_d;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rdata_q <= `CIP_RDATA_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      level_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      level_q <= level_d;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      out_q <= '0;
      oe_q <= '0;
      pull_q <= '0;
    end
    else
    begin
      out_q <= out_d;
      oe_q <= oe_d;
      pull_q <= pull_d;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wake_q <= '0;
      timer_q <= '0;
      serial_q <= '0;
    end
    else
    begin
      wake_q <= wake_d;
      timer_q <= timer_d;
      serial_q <= serial_d;
    end
  end

  assign rd_data_out = rdata_q;
  assign pin_out_out = out_q;
  assign pin_oe_out = oe_q;
  assign pin_pull_out = pull_q;
  assign wakeup_level_out = wake_q;
  assign timer_inputs_out = timer_q;
  assign serial_inputs_out = serial_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_cfg_write_store: assert property (
    (bus_req_in.wr && sel && field == `CIP_OFS_CFG)
    |=> cfg_q[$past(port_idx)] == $past(bus_req_in.wdata))
    else $error("configuration write not stored");

  a_data_write_store: assert property (
    (bus_req_in.wr && sel && field == `CIP_OFS_DATA)
    |=> data_q[$past(port_idx)] == $past(bus_req_in.wdata) && pin_out_out[1] == data_q[1])
    else $error("data write not stored or not driven");

  a_oe_from_cfg: assert property (
    pin_oe_out[3:1] == cfg_q[3:1] && pin_out_out[3:1] == data_q[3:1])
    else $error("pad drive does not follow configuration");

  a_pull_mode: assert property (
    pin_pull_out[3:1] == (~cfg_q[3:1] & data_q[3:1]))
    else $error("weak pull-up does not follow configuration and data");

  a_pin_read_value: assert property (
    (bus_req_in.rd && sel && field == `CIP_OFS_PIN)
    |=> rd_data_out == $past(level_q[port_idx]))
    else $error("pin read returns wrong level");

  a_pin_write_ignored: assert property (
    (bus_req_in.wr && sel && field == `CIP_OFS_PIN)
    |=> cfg_q == $past(cfg_q) && data_q == $past(data_q))
    else $error("write to pin address changed a register");

  a_unmapped_zero: assert property (
    (bus_req_in.rd && (!sel || field == `CIP_OFS_NONE)) |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");

  a_filter_hold: assert property (
    (sync2_q != sync3_q) |=> (level_q & $past(sync2_q ^ sync3_q))
      == ($past(level_q) & $past(sync2_q ^ sync3_q)))
    else $error("level moved while synchroniser stages disagree");

  a_pin_follow: assert property (
    (arst_n_in && $stable(pin_in)) [*5] |-> level_q == $past(pin_in, 4))
    else $error("stable pin level not seen after synchroniser");

  a_wakeup_route: assert property (
    wakeup_level_out == level_q[0])
    else $error("wakeup levels do not match filtered port");

  a_timer_route: assert property (
    timer_inputs_out == level_q[0][7:4])
    else $error("timer inputs not routed from pins 7 to 4");

  a_serial_route: assert property (
    serial_transmit_en_in |=> pin_oe_out[0][2] && pin_out_out[0][2] == $past(serial_transmit_pin_in)
      && serial_inputs_out == {level_q[0][3], level_q[0][1]})
    else $error("serial pins not routed");

  a_port0_drive: assert property (
    pin_oe_out[0][7:3] == cfg_q[0][7:3] && pin_oe_out[0][1:0] == cfg_q[0][1:0]
      && pin_out_out[0][7:3] == data_q[0][7:3] && pin_out_out[0][1:0] == data_q[0][1:0])
    else $error("wakeup port pad drive does not follow configuration");

  a_port0_pull: assert property (
    pin_pull_out[0][7:3] == (~cfg_q[0][7:3] & data_q[0][7:3])
      && pin_pull_out[0][1:0] == (~cfg_q[0][1:0] & data_q[0][1:0]))
    else $error("wakeup port weak pull-up does not follow configuration and data");

  a_tx_release: assert property (
    !serial_transmit_en_in |=> pin_oe_out[0][2] == cfg_q[0][2]
      && pin_out_out[0][2] == data_q[0][2]
      && pin_pull_out[0][2] == (~cfg_q[0][2] & data_q[0][2]))
    else $error("transmit pin not returned to port control");

  a_tx_no_pull: assert property (
    serial_transmit_en_in |=> !pin_pull_out[0][2])
    else $error("transmit pin still pulled up while driven");

  a_data_read_value: assert property (
    (bus_req_in.rd && sel && field == `CIP_OFS_DATA)
    |=> rd_data_out == $past(data_q[port_idx]))
    else $error("data read returns wrong value");

  a_cfg_read_value: assert property (
    (bus_req_in.rd && sel && field == `CIP_OFS_CFG)
    |=> rd_data_out == $past(cfg_q[port_idx]))
    else $error("configuration read returns wrong value");

  a_level_agree: assert property (
    (sync2_q == sync3_q) |=> level_q == $past(sync3_q))
    else $error("level not taken when synchroniser stages agree");

  c_cfg_write: cover property (bus_req_in.wr && sel && field == `CIP_OFS_CFG);
  c_pin_read: cover property (bus_req_in.rd && sel && field == `CIP_OFS_PIN);
  c_pull_mode: cover property (|pin_pull_out);
  c_tx_override: cover property (serial_transmit_en_in ##1 pin_oe_out[0][2]);
  c_data_read: cover property (bus_req_in.rd && sel && field == `CIP_OFS_DATA);
endmodule

//--- rtl/cip_defines.svh
// Constants of the configurable I/O port block: offsets, fields and reset values
`ifndef CIP_DEFINES_SVH
`define CIP_DEFINES_SVH

`define CIP_NUM_PORTS 4
`define CIP_PORT_WIDTH 8
`define CIP_ADDR_WIDTH 8
`define CIP_BASE_HI 4'hd
`define CIP_BASE_HI_MSB 7
`define CIP_BASE_HI_LSB 4
`define CIP_PORT_SEL_MSB 3
`define CIP_PORT_SEL_LSB 2
`define CIP_FIELD_MSB 1
`define CIP_FIELD_LSB 0
`define CIP_OFS_DATA 2'h0
`define CIP_OFS_CFG 2'h1
`define CIP_OFS_PIN 2'h2
`define CIP_OFS_NONE 2'h3
`define CIP_IDX_WAKE_PORT 2'h0
`define CIP_IDX_GEN_PORT 2'h1
`define CIP_BIT_TIMER3_B 7
`define CIP_BIT_TIMER3_A 6
`define CIP_BIT_TIMER2_B 5
`define CIP_BIT_TIMER2_A 4
`define CIP_BIT_SER_RX 3
`define CIP_BIT_SER_TX 2
`define CIP_BIT_SER_CLK 1
`define CIP_CFG_RESET 8'h00
`define CIP_DATA_RESET 8'h00
`define CIP_RDATA_RESET 8'h00

`endif

//--- rtl/cip_pkg.sv
// Types shared by the configurable I/O port block
package cip_pkg;
  typedef logic [3:0][7:0] cip_port_vec_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cip_bus_req_type;

  typedef struct packed {
    logic timer3_input_b;
    logic timer3_input_a;
    logic timer2_input_b;
    logic timer2_input_a;
  } cip_timer_in_type;

  typedef struct packed {
    logic serial_receive_pin;
    logic serial_clock_pin;
  } cip_serial_in_type;
endpackage

//--- sim/cip_pad_model.sv
// Board model: resolves every pad from device drive, weak pull-up and outside drivers
module cip_pad_model (
  input wire logic clk_in,
  input cip_pkg::cip_port_vec_type pin_out_in,
  input cip_pkg::cip_port_vec_type pin_oe_in,
  input cip_pkg::cip_port_vec_type pin_pull_in,
  input cip_pkg::cip_port_vec_type ext_en_in,
  input cip_pkg::cip_port_vec_type ext_lvl_in,
  output cip_pkg::cip_port_vec_type pin_lvl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import cip_pkg::*;
  // Two-state so a floating pad never sticks at unknown after power-up
  bit [3:0][7:0] last_q;
  // Undriven and unpulled pads wander away from their last level
  always_comb
  begin
    pin_lvl_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_en_in & ext_lvl_in) |
      (~pin_oe_in & ~ext_en_in & pin_pull_in) |
      (~pin_oe_in & ~ext_en_in & ~pin_pull_in & ~last_q);
  end
  always_ff @(posedge clk_in)
  begin
    last_q <= pin_lvl_out;
  end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the configurable I/O ports
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cip_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  cip_bus_req_type req = '0;
  logic [7:0] rd_data;
  logic [7:0] wake;
  cip_port_vec_type lvl, pout, poe, ppull;
  cip_port_vec_type ext_en = '0;
  cip_port_vec_type ext_lvl = '0;
  cip_timer_in_type tmr;
  cip_serial_in_type ser;
  logic tx_en = 1'b0;
  logic tx_pin = 1'b0;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] dat, exp_lvl;

  always #5 clk = ~clk;

  cip_io_ports cip_io_ports_inst (.clk_in(clk), .arst_n_in(arst_n), .bus_req_in(req),
    .rd_data_out(rd_data), .pin_in(lvl), .pin_out_out(pout), .pin_oe_out(poe),
    .pin_pull_out(ppull), .wakeup_level_out(wake), .timer_inputs_out(tmr),
    .serial_inputs_out(ser), .serial_transmit_en_in(tx_en), .serial_transmit_pin_in(tx_pin));

  cip_pad_model cip_pad_model_inst (.clk_in(clk), .pin_out_in(pout), .pin_oe_in(poe),
    .pin_pull_in(ppull), .ext_en_in(ext_en), .ext_lvl_in(ext_lvl), .pin_lvl_out(lvl));

  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= cip_bus_req_type'{a, 1'b1, 1'b0, d};
    @(posedge clk);
    req <= '0;
  endtask

  // Read data stands for one cycle just after the edge that takes the read
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= cip_bus_req_type'{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk);
    req <= '0;
    #1 check(rd_data, exp);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      rd(8'hd0 + 8'(4 * p), 8'h00);
      rd(8'hd1 + 8'(4 * p), 8'h00);
      rd(8'hd3 + 8'(4 * p), 8'h00);
      check(poe[p], 8'h00);
    end
    // Outside drivers hold their levels many cycles
    ext_en <= {4{8'h0f}};
    for (int p = 0; p < 4; p++)
    begin
      dat = 8'h96 + 8'(p);
      ext_lvl[p] <= 8'h09 ^ 8'(p);
      wr(8'hd1 + 8'(4 * p), 8'hf0);
      wr(8'hd0 + 8'(4 * p), dat);
      wr(8'hd2 + 8'(4 * p), 8'h3c);
    end
    repeat (6) @(posedge clk);
    for (int p = 0; p < 4; p++)
    begin
      dat = 8'h96 + 8'(p);
      exp_lvl = (8'hf0 & dat) | (8'h0f & (8'h09 ^ 8'(p)));
      check(poe[p], 8'hf0);
      check(pout[p] & 8'hf0, dat & 8'hf0);
      check(ppull[p], dat & 8'h0f);
      rd(8'hd0 + 8'(4 * p), dat);
      rd(8'hd1 + 8'(4 * p), 8'hf0);
      rd(8'hd2 + 8'(4 * p), exp_lvl);
    end
    exp_lvl = 8'h90 | 8'h09;
    check(wake, exp_lvl);
    check({4'h0, tmr}, {4'h0, exp_lvl[7:4]});
    check({6'h00, ser}, {6'h00, exp_lvl[3], exp_lvl[1]});
    @(posedge clk);
    tx_en <= 1'b1;
    tx_pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(poe[0], 8'hf4);
    check({7'h00, pout[0][2]}, 8'h01);
    check(ppull[0], 8'h02);
    @(posedge clk);
    tx_pin <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({7'h00, pout[0][2]}, 8'h00);
    @(posedge clk);
    tx_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(poe[0], 8'hf0);
    check(ppull[0], 8'h06);
    // Second reset in mid-run, held for a full microsecond
    @(posedge clk);
    ext_en[2] <= 8'h00;
    arst_n <= 1'b0;
    repeat (100) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    check(wake, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      check(poe[p], 8'h00);
      check(pout[p], 8'h00);
      check(ppull[p], 8'h00);
      rd(8'hd0 + 8'(4 * p), 8'h00);
      rd(8'hd1 + 8'(4 * p), 8'h00);
    end
    // Floating port pulled up by its own weak pull-ups
    wr(8'hd8, 8'hff);
    repeat (4) @(posedge clk);
    #1 check(ppull[2], 8'hff);
    rd(8'hda, 8'hff);
    wr(8'hd7, 8'hff);
    wr(8'h55, 8'hff);
    rd(8'hd4, 8'h00);
    rd(8'hd5, 8'h00);
    rd(8'h55, 8'h00);
    end_sim();
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule
